// ### logic/fp_cfg.svh
/*
 * Constants for the front-panel status logic: register offsets, field
 * positions, reset values, sleep codes and timing figures.
 * Assumes it is included by bare name from the module.
 */
`ifndef FP_CFG_SVH
`define FP_CFG_SVH

`define FP_ADDR_CTRL_LO 4'h0
`define FP_ADDR_CTRL_HI 4'h4
`define FP_ADDR_STATUS 4'h8

`define FP_SWFAIL_BIT 0
`define FP_GREEN_EN_BIT 0
`define FP_CTRL_RST 8'h00

`define FP_SLP_S0 2'h0
`define FP_SLP_S3 2'h1
`define FP_SLP_S4 2'h2
`define FP_SLP_S5 2'h3

`define FP_CLK_HZ 25000000
`define FP_BLINK_HALF_MS 500
`define FP_HOLD_MS 4000

`endif

// ### logic/fp_pkg.sv
/*
 * Types for the front-panel status logic.
 * Assumes fp_cfg.svh is on the include path.
 */
package fp_pkg;

    typedef struct packed {
        logic green;
        logic red;
    } led2_t;

    typedef struct packed {
        logic green;
        logic yellow;
    } disk_t;

    typedef enum logic [1:0] {PWR_ON, PWR_S3, PWR_S4, PWR_OFF} pwr_t;

    typedef struct packed {
        logic [1:0] sleep;
        logic handle_open;
        logic power_fault;
        logic rails_ok;
        logic red_gpio;
        logic sata_pch;
        logic sata_ctrl;
        logic proc_hot;
        logic supply_fail_n;
        logic power_event;
    } pins_t;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic evt_prev;
        logic [1:0] code_prev;
        logic [23:0] div;
        logic tick;
        logic blink;
        logic [3:0] hold;
        pwr_t pwr;
        logic after_rst;
        logic act_seen;
        logic [7:0] ctrl_lo;
        logic [7:0] ctrl_hi;
        logic [7:0] rdata;
        led2_t pg;
        led2_t gp;
        disk_t hd;
        logic ot;
        logic supply_en_n;
        logic fail_gpio;
    } st_t;

endpackage

// ### logic/front_panel_status_indicator.sv
/*
 * Front-panel indicator decode and main-supply control for a CPU card.
 * Assumes all pin inputs are asynchronous to clk and that software uses
 * the plain register port with read data one cycle after the strobe.
 */
`timescale 1ns/1ps
`include "fp_cfg.svh"

module front_panel_status_indicator
    import fp_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC =
        `FP_CLK_HZ / 1000 * `FP_BLINK_HALF_MS
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [7:0] rdata,
    input wire logic [1:0] sleep_state,
    input wire logic handle_open,
    input wire logic power_fault,
    input wire logic rails_ok,
    input wire logic red_indicator_gpio,
    input wire logic sata_act_chipset,
    input wire logic sata_act_ctrl,
    input wire logic proc_hot,
    input wire logic supply_fail_n,
    input wire logic power_event,
    output led2_t power_good_indicator,
    output led2_t general_purpose_indicator,
    output disk_t disk_activity_indicator,
    output logic overtemp_indicator,
    output logic main_supply_enable_n,
    output logic supply_fail_gpio
);

    localparam int HOLD_TICKS = `FP_HOLD_MS / `FP_BLINK_HALF_MS;
    localparam logic [23:0] DIV_LAST = 24'(BLINK_HALF_CYC - 1);
    localparam logic [3:0] HOLD_LAST = 4'(HOLD_TICKS - 1);

    st_t q;
    st_t d;
    logic evt_rise;
    logic sw_fail;
    logic asleep;

    assign evt_rise = q.s2.power_event & ~q.evt_prev;
    assign sw_fail = q.ctrl_lo[`FP_SWFAIL_BIT];
    assign asleep = (q.pwr != PWR_ON);

    always_comb
    begin
        d = q;
        d.s1 = '{sleep: sleep_state,
                 handle_open: handle_open,
                 power_fault: power_fault,
                 rails_ok: rails_ok,
                 red_gpio: red_indicator_gpio,
                 sata_pch: sata_act_chipset,
                 sata_ctrl: sata_act_ctrl,
                 proc_hot: proc_hot,
                 supply_fail_n: supply_fail_n,
                 power_event: power_event};
        d.s2 = q.s1;
        d.evt_prev = q.s2.power_event;
        d.code_prev = q.s2.sleep;

        // One divider feeds every blink and the handle timer
        d.tick = 1'b0;
        if (q.div == DIV_LAST)
        begin
            d.div = '0;
            d.tick = 1'b1;
            d.blink = ~q.blink;
        end
        else
        begin
            d.div = q.div + 24'h000001;
        end

        // Timer runs in half-second steps, so four seconds is coarse
        if (!q.s2.handle_open)
        begin
            d.hold = '0;
        end
        else if (q.tick && q.hold != HOLD_LAST)
        begin
            d.hold = q.hold + 4'h1;
        end

        case (q.pwr)
            PWR_OFF:
            begin
                if (evt_rise)
                begin
                    d.pwr = PWR_ON;
                end
            end
            PWR_ON, PWR_S3, PWR_S4:
            begin
                case (q.s2.sleep)
                    `FP_SLP_S0: d.pwr = PWR_ON;
                    `FP_SLP_S3: d.pwr = PWR_S3;
                    `FP_SLP_S4: d.pwr = PWR_S4;
                    default:
                    begin
                        // Entry only on the code's edge, so a power event
                        // is not undone by a stale soft-off code
                        if (q.code_prev != `FP_SLP_S5)
                        begin
                            d.pwr = PWR_OFF;
                        end
                    end
                endcase
            end
            default: d.pwr = PWR_ON;
        endcase
        if (q.s2.handle_open && q.tick && q.hold == HOLD_LAST)
        begin
            d.pwr = PWR_OFF;
        end

        // Set wins over the tick that would clear it
        if (q.s2.sata_pch)
        begin
            d.act_seen = 1'b1;
        end
        else if (q.tick)
        begin
            d.act_seen = 1'b0;
        end

        if (we)
        begin
            case (addr)
                `FP_ADDR_CTRL_LO: d.ctrl_lo = wdata;
                `FP_ADDR_CTRL_HI:
                begin
                    d.ctrl_hi = wdata;
                    d.after_rst = 1'b0;
                end
                default: ;
            endcase
        end

        d.rdata = '0;
        if (re)
        begin
            case (addr)
                `FP_ADDR_CTRL_LO: d.rdata = q.ctrl_lo;
                `FP_ADDR_CTRL_HI: d.rdata = q.ctrl_hi;
                `FP_ADDR_STATUS:
                    d.rdata = {q.s2.supply_fail_n, q.s2.rails_ok,
                               q.s2.power_fault, q.s2.handle_open,
                               q.after_rst, q.act_seen, 2'(q.pwr)};
                default: d.rdata = '0;
            endcase
        end

        // Power-good: fault, then software, then handle, then state
        if (q.s2.power_fault)
        begin
            d.pg = '{green: 1'b0, red: 1'b1};
        end
        else if (sw_fail)
        begin
            d.pg = '{green: 1'b0, red: q.blink};
        end
        else if (q.s2.handle_open)
        begin
            d.pg = '{green: q.blink, red: q.blink};
        end
        else if (asleep)
        begin
            d.pg = '0;
        end
        else
        begin
            d.pg = '{green: q.s2.rails_ok, red: 1'b0};
        end

        // Sleep patterns own the whole general indicator
        case (q.pwr)
            PWR_OFF, PWR_S4: d.gp = '{green: 1'b1, red: 1'b0};
            PWR_S3: d.gp = '0;
            default:
            begin
                if (q.after_rst)
                begin
                    d.gp = '{green: 1'b0, red: q.blink};
                end
                else
                begin
                    d.gp.green = q.ctrl_hi[`FP_GREEN_EN_BIT];
                    d.gp.red = q.s2.red_gpio;
                end
            end
        endcase

        case (q.pwr)
            PWR_OFF, PWR_S3: d.hd.green = 1'b1;
            PWR_S4: d.hd.green = 1'b0;
            default: d.hd.green = q.act_seen & q.blink;
        endcase
        d.hd.yellow = q.s2.sata_ctrl;

        d.ot = q.s2.proc_hot;
        d.supply_en_n = (q.pwr == PWR_OFF);
        d.fail_gpio = q.s2.supply_fail_n;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.pwr <= PWR_ON;
            q.after_rst <= 1'b1;
            q.ctrl_lo <= `FP_CTRL_RST;
            q.ctrl_hi <= `FP_CTRL_RST;
            q.fail_gpio <= 1'b1;
            // Syncs start at the idle level: no false warning after reset
            q.s1.supply_fail_n <= 1'b1;
            q.s2.supply_fail_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign power_good_indicator = q.pg;
    assign general_purpose_indicator = q.gp;
    assign disk_activity_indicator = q.hd;
    assign overtemp_indicator = q.ot;
    assign main_supply_enable_n = q.supply_en_n;
    assign supply_fail_gpio = q.fail_gpio;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_soft_off;
        q.pwr == PWR_OFF && !q.s2.power_fault && !sw_fail
            && !q.s2.handle_open
        |=> q.pg == 2'b00 && q.gp == 2'b10 && q.hd.green;
    endproperty
    a_soft_off: assert property (p_soft_off)
        else $error("soft-off pattern wrong");

    property p_hibernate;
        q.pwr == PWR_S4 && !q.s2.power_fault && !sw_fail
            && !q.s2.handle_open
        |=> q.pg == 2'b00 && q.gp == 2'b10 && !q.hd.green;
    endproperty
    a_hibernate: assert property (p_hibernate)
        else $error("hibernate pattern wrong");

    property p_standby;
        q.pwr == PWR_S3 && !q.s2.power_fault && !sw_fail
            && !q.s2.handle_open
        |=> q.pg == 2'b00 && q.gp == 2'b00 && q.hd.green;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby pattern wrong");

    property p_fault_red;
        q.s2.power_fault |=> q.pg == 2'b01;
    endproperty
    a_fault_red: assert property (p_fault_red)
        else $error("fault not shown steady red");

    property p_sw_blink;
        sw_fail && !q.s2.power_fault
        |=> !q.pg.green && q.pg.red == $past(q.blink);
    endproperty
    a_sw_blink: assert property (p_sw_blink)
        else $error("software failure not blinking red");

    property p_healthy;
        !asleep && q.s2.rails_ok && !q.s2.power_fault && !sw_fail
            && !q.s2.handle_open
        |=> q.pg == 2'b10;
    endproperty
    a_healthy: assert property (p_healthy)
        else $error("healthy board not steady green");

    property p_handle_yellow;
        q.s2.handle_open && !q.s2.power_fault && !sw_fail
        |=> q.pg.green == q.pg.red && q.pg.red == $past(q.blink);
    endproperty
    a_handle_yellow: assert property (p_handle_yellow)
        else $error("open handle not blinking yellow");

    property p_blink_tick;
        q.blink != $past(q.blink) |-> q.tick;
    endproperty
    a_blink_tick: assert property (p_blink_tick)
        else $error("blink changed without divider tick");

    property p_override;
        q.s2.handle_open && q.tick && q.hold == HOLD_LAST
        |=> q.pwr == PWR_OFF ##1 q.supply_en_n;
    endproperty
    a_override: assert property (p_override)
        else $error("handle override did not reach soft-off");

    property p_off_held;
        q.pwr == PWR_OFF && !evt_rise |=> q.pwr == PWR_OFF;
    endproperty
    a_off_held: assert property (p_off_held)
        else $error("soft-off left without power event");

    property p_supply_off;
        q.pwr == PWR_OFF |=> q.supply_en_n;
    endproperty
    a_supply_off: assert property (p_supply_off)
        else $error("supply enable low in soft-off");

    property p_fail_pass;
        1'b1 |=> q.fail_gpio == $past(q.s2.supply_fail_n);
    endproperty
    a_fail_pass: assert property (p_fail_pass)
        else $error("power-fail level not passed on");

    property p_yellow;
        1'b1 |=> q.hd.yellow == $past(q.s2.sata_ctrl);
    endproperty
    a_yellow: assert property (p_yellow)
        else $error("controller activity not yellow");

    property p_green_en;
        !asleep && !q.after_rst
        |=> q.gp.green == $past(q.ctrl_hi[`FP_GREEN_EN_BIT]);
    endproperty
    a_green_en: assert property (p_green_en)
        else $error("general green does not follow enable bit");

    c_override: cover property (q.pwr != PWR_OFF ##1 q.pwr == PWR_OFF
        ##1 q.supply_en_n);
    c_wake: cover property (q.pwr == PWR_OFF && evt_rise
        ##1 q.pwr == PWR_ON);
    c_sw_blink: cover property (sw_fail && q.pg.red ##1 sw_fail);
    c_disk: cover property (q.hd.green && !asleep);

endmodule

// ### test/platform_supply_model.sv
/*
 Chipset and supply model: red-request GPIO, power-fail warning and
 the handle power-button event towards the status logic.
 Assumes bench requests change just after a rising clk edge.
*/
`timescale 1ns/1ps
module platform_supply_model
(
    input wire logic clk,
    input wire logic red_req,
    input wire logic fail_req,
    input wire logic press_req,
    output logic red_indicator_gpio,
    output logic supply_fail_n,
    output logic power_event
);
    logic [2:0] press_cnt;

    initial
    begin
        red_indicator_gpio = 1'b0;
        supply_fail_n = 1'b1;
        press_cnt = 3'h0;
    end

    // Event held four edges so the two-flop sync cannot miss it
    always @(posedge clk)
    begin
        red_indicator_gpio <= red_req;
        supply_fail_n <= ~fail_req;
        if (press_req)
            press_cnt <= 3'h4;
        else if (press_cnt != 3'h0)
            press_cnt <= press_cnt - 3'h1;
    end

    assign power_event = press_cnt != 3'h0;
endmodule

// ### test/tb.sv
/*
 Self-checking bench for the front-panel status logic.
 Assumes a short blink half period of 4 cycles set by parameter.
*/
`timescale 1ns/1ps
module tb
    import fp_pkg::*;
;
    typedef struct packed {
        logic [1:0] sl;
        logic [4:0] in;
        logic [8:0] out;
    } row_t;

    // in: fault red ctl hot fail; out: pg gp hd ot en_n gpio
    row_t rows [7] = '{
        '{2'h0, 5'b00000, 9'b10_10_00_001},
        '{2'h0, 5'b01111, 9'b10_11_01_100},
        '{2'h0, 5'b10000, 9'b01_10_00_001},
        '{2'h1, 5'b00000, 9'b00_00_10_001},
        '{2'h2, 5'b01000, 9'b00_10_00_001},
        '{2'h2, 5'b00100, 9'b00_10_01_001},
        '{2'h3, 5'b00000, 9'b00_10_10_011}
    };

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] rdata;
    logic [1:0] sleep_state = 2'h0;
    logic handle_open = 1'b0;
    logic power_fault = 1'b0;
    logic rails_ok = 1'b1;
    logic sata_act_chipset = 1'b0;
    logic sata_act_ctrl = 1'b0;
    logic proc_hot = 1'b0;
    logic red_req = 1'b0;
    logic fail_req = 1'b0;
    logic press_req = 1'b0;
    logic red_gpio;
    logic sf_n;
    logic pev;
    led2_t pg;
    led2_t gp;
    disk_t hd;
    logic ot;
    logic sup_en_n;
    logic fgpio;
    logic [1:0] pg_or, pg_and, gp_or, gp_and, hd_or, hd_and;
    int n_errors = 0;
    int n_compared = 0;
    int n;

    always #20 clk = ~clk;

    platform_supply_model u_model (.clk(clk), .red_req(red_req),
        .fail_req(fail_req), .press_req(press_req),
        .red_indicator_gpio(red_gpio), .supply_fail_n(sf_n),
        .power_event(pev));

    front_panel_status_indicator #(.BLINK_HALF_CYC(4)) u_dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .we(we),
        .re(re), .rdata(rdata), .sleep_state(sleep_state),
        .handle_open(handle_open), .power_fault(power_fault),
        .rails_ok(rails_ok), .red_indicator_gpio(red_gpio),
        .sata_act_chipset(sata_act_chipset), .sata_act_ctrl(sata_act_ctrl),
        .proc_hot(proc_hot), .supply_fail_n(sf_n), .power_event(pev),
        .power_good_indicator(pg), .general_purpose_indicator(gp),
        .disk_activity_indicator(hd), .overtemp_indicator(ot),
        .main_supply_enable_n(sup_en_n), .supply_fail_gpio(fgpio));

    task automatic check(input string name, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1;
        check("rdata", rdata, exp);
    endtask

    // Or and and of each indicator over a span show steady versus blink
    task automatic watch(input int cycles);
        pg_or = 2'b00;
        gp_or = 2'b00;
        hd_or = 2'b00;
        pg_and = 2'b11;
        gp_and = 2'b11;
        hd_and = 2'b11;
        repeat (cycles)
        begin
            @(posedge clk);
            #1;
            pg_or |= pg;
            gp_or |= gp;
            hd_or |= hd;
            pg_and &= pg;
            gp_and &= gp;
            hd_and &= hd;
        end
    endtask

    task automatic wait_en(input logic v);
        n = 0;
        while (sup_en_n !== v && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sup_en_n !== v)
        begin
            n_errors++;
            print_verdict;
        end
    endtask

    task automatic press;
        @(posedge clk);
        press_req <= 1'b1;
        @(posedge clk);
        press_req <= 1'b0;
    endtask

    initial
    begin
        repeat (15) @(posedge clk);
        #1;
        check("pg_rst", pg, 2'b00);
        check("en_rst", sup_en_n, 1'b0);
        check("gpio_rst", fgpio, 1'b1);
        check("rdata_rst", rdata, 8'h00);
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("pg_rel", pg, 2'b00);
        check("gpio_rel", fgpio, 1'b1);
        @(posedge clk);
        watch(20);
        check("pg_after", {pg_or, pg_and}, 4'hA);
        check("gp_after", {gp_or, gp_and}, 4'h4);
        rd(4'h8, 8'hC8);
        @(posedge clk);
        #1;
        check("rdata_idle", rdata, 8'h00);
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'hC8);
        rd(4'hC, 8'h00);
        wr(4'h4, 8'h01);
        rd(4'h4, 8'h01);
        foreach (rows[i])
        begin
            @(posedge clk);
            sleep_state <= rows[i].sl;
            {power_fault, red_req, sata_act_ctrl, proc_hot, fail_req}
                <= rows[i].in;
            repeat (8) @(posedge clk);
            #1;
            check("pg", pg, rows[i].out[8:7]);
            check("gp", gp, rows[i].out[6:5]);
            check("hd", hd, rows[i].out[4:3]);
            check("ot", ot, rows[i].out[2]);
            check("en_n", sup_en_n, rows[i].out[1]);
            check("fail_gpio", fgpio, rows[i].out[0]);
        end
        @(posedge clk);
        sleep_state <= 2'h0;
        repeat (10) @(posedge clk);
        #1;
        check("en_held", sup_en_n, 1'b1);
        press;
        wait_en(1'b0);
        @(posedge clk);
        rails_ok <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check("pg_rails", pg, 2'b00);
        @(posedge clk);
        rails_ok <= 1'b1;
        wr(4'h0, 8'h01);
        watch(16);
        check("pg_swfail", {pg_or, pg_and}, 4'h4);
        rd(4'h0, 8'h01);
        @(posedge clk);
        power_fault <= 1'b1;
        handle_open <= 1'b1;
        repeat (6) @(posedge clk);
        watch(10);
        check("pg_prio", {pg_or, pg_and}, 4'h5);
        @(posedge clk);
        power_fault <= 1'b0;
        handle_open <= 1'b0;
        wr(4'h0, 8'h00);
        repeat (6) @(posedge clk);
        watch(10);
        check("pg_back", {pg_or, pg_and}, 4'hA);
        @(posedge clk);
        sata_act_chipset <= 1'b1;
        repeat (6) @(posedge clk);
        watch(16);
        check("hd_blink", {hd_or[1], hd_and[1]}, 2'b10);
        @(posedge clk);
        sata_act_chipset <= 1'b0;
        handle_open <= 1'b1;
        repeat (6) @(posedge clk);
        watch(16);
        check("pg_handle", {pg_or, pg_and}, 4'hC);
        wait_en(1'b1);
        check("hold_long", n + 22 >= 32 && n + 22 <= 35, 1'b1);
        @(posedge clk);
        handle_open <= 1'b0;
        press;
        wait_en(1'b0);
        print_verdict;
    end
endmodule
